// >>> hw/stp_timer_core.sv
// Timer, watchdog and shared prescaler with the processor register file
`timescale 1ns/1ps
// What this block does
// - One 8-bit counter serves timer or watchdog, never both.
// - Assignment bit 3 of option register at zero routes prescaler to timer.
// - Option bits 2..0 select the division ratio.
// - Prescaler count is never readable or writable by software.
// - Any write to timer count clears prescaler while assigned to timer.
// - Watchdog clear instruction clears prescaler and watchdog when assigned to watchdog.
// - Assignment may change any time without reset or halt.
module stp_timer_core
   import stp_pkg::*;
(
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_nrst,
   input  wire logic [REG_AW-1:0]    i_addr,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   input  wire logic [7:0]           i_wdata,
   input  wire logic                 i_wdt_clear,
   input  wire logic                 i_wdt_enable,
   input  wire logic                 i_wdt_osc_tick,
   input  wire logic                 i_ext_clk,
   output logic      [7:0]           o_rdata,
   output logic                      o_wdt_reset,
   output logic                      o_timer_irq,
   output logic      [7:0]           o_pin_dir
);
   stp_prescale_if p_if ();

   logic [7:0]       timer_r, timer_nxt;
   logic [7:0]       option_r, option_nxt;
   logic [7:0]       intc_r, intc_nxt;
   logic [7:0]       pindir_r, pindir_nxt;
   logic [WDT_W-1:0] wdt_r, wdt_nxt;
   logic             wdt_rst_nxt;
   logic [7:0]       rdata_nxt;
   logic             irq_nxt;
   logic             ext_q_r;
   logic             ext_edge;
   logic             tmr_src_tick;
   logic             timer_inc;
   logic             timer_wr;
   logic             to_wdt;
   logic             wr_option;
   logic             wr_intc;
   logic             wr_pindir;
   logic             timer_ovf;
   logic             wdt_tick;

   // Address decode shared by read and write paths
   function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] r);
      return a == r;
   endfunction

   assign to_wdt   = option_r[OPT_ASSIGN_BIT];
   assign timer_wr = i_wr && hit(i_addr, ADDR_TIMER_COUNT);

   // Timer source: instruction clock or selected edge of external pin
   assign ext_edge     = option_r[OPT_EDGE_BIT] ? (ext_q_r && !i_ext_clk) : (!ext_q_r && i_ext_clk);
   assign tmr_src_tick = option_r[OPT_SRC_BIT] ? ext_edge : 1'b1;

   // Drive the shared prescaler from whichever party owns it
   assign p_if.to_wdt  = to_wdt;
   assign p_if.ratio   = option_r[OPT_RATIO_MSB:0];
   assign p_if.tick_in = to_wdt ? i_wdt_osc_tick : tmr_src_tick;
   assign p_if.clear   = to_wdt ? i_wdt_clear : timer_wr;

   // Timer undivided when prescaler belongs to the watchdog
   assign timer_inc = to_wdt ? tmr_src_tick : p_if.tick_out;

   // Notes for the software that drives this block:
   // - The prescaler count itself is invisible; only its owner and ratio read back.
   // - A timer write restarts the prescaler only while the timer owns it, so a write
   //   right after a handover to the watchdog leaves the count untouched.
   // - Handing the prescaler to the watchdog with a small ratio can make the watchdog
   //   wrap almost at once; clear the watchdog, clear the timer, park a large ratio,
   //   clear the watchdog again and only then choose the final ratio.
   // - Handing it back to the timer needs a watchdog clear first, even while the
   //   watchdog is disabled, because the count still holds a partial period.
   // - Ownership may change on any cycle; a divided tick already in flight is
   //   delivered to the new owner one cycle later.
   // - The watchdog reset request is a single-cycle pulse; whoever resets the device
   //   must stretch it if a longer pulse is needed.
   // - Interrupt control answers at two addresses; both reach the same register.
   // - Hardware sets the overflow flag on a wrap, and a software write of one sets it too; software clears it by writing zero.
   // - Pin direction bits 7 and 6 do not exist and always read as zero.
   // - The external clock pin is taken as synchronous; an edge is one cycle of change.
   stp_prescaler u_psc (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .p_if      (p_if)
   );

   // Per-register write strobes, decoded once and shared by the next-state logic
   assign wr_option = i_wr && hit(i_addr, ADDR_OPTION);
   assign wr_intc   = i_wr && (hit(i_addr, ADDR_INTR_CTRL) || hit(i_addr, ADDR_INTR_CTRL_HI));
   assign wr_pindir = i_wr && hit(i_addr, ADDR_PIN_DIR);

   // Timer steps past its top value; a write in the same cycle replaces the step
   assign timer_ovf = timer_inc && !timer_wr && (&timer_r);

   // Watchdog step: postscaled tick while it owns the prescaler, raw oscillator tick otherwise
   assign wdt_tick  = i_wdt_enable && (to_wdt ? p_if.tick_out : i_wdt_osc_tick);

   // Next values of the software-visible control registers
   always_comb begin
      option_nxt = option_r;
      intc_nxt   = intc_r;
      pindir_nxt = pindir_r;
      if (wr_option) begin
         option_nxt = i_wdata;
      end
      if (wr_intc) begin
         intc_nxt = i_wdata;
      end
      if (wr_pindir) begin
         pindir_nxt = i_wdata & MASK_PIN_DIR;                   // Upper direction bits do not exist
      end
      // Hardware set of the overflow flag wins over a software clear in the same cycle
      if (timer_ovf) begin
         intc_nxt[INTC_OVF_FLAG_BIT] = 1'b1;
      end
   end

   // Control registers; the option reset value leaves the prescaler on the watchdog side
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         option_r <= RST_OPTION;
         intc_r   <= RST_INTR_CTRL;
         pindir_r <= RST_PIN_DIR;
      end else begin
         option_r <= option_nxt;
         intc_r   <= intc_nxt;
         pindir_r <= pindir_nxt;
      end
   end

   // Timer count: a write loads the new value and takes priority over a step
   always_comb begin
      timer_nxt = timer_r;
      if (timer_wr) begin
         timer_nxt = i_wdata;
      end else if (timer_inc) begin
         timer_nxt = timer_r + 8'h01;
      end
   end

   // Timer count and the previous level of the external clock pin for edge detection
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_r <= RST_TIMER_COUNT;
         ext_q_r <= 1'b0;
      end else begin
         timer_r <= timer_nxt;
         ext_q_r <= i_ext_clk;
      end
   end

   // Watchdog counter; the clear instruction restarts it whoever owns the prescaler
   always_comb begin
      wdt_nxt     = wdt_r;
      wdt_rst_nxt = 1'b0;
      if (i_wdt_clear) begin
         wdt_nxt = '0;
      end else if (wdt_tick) begin
         wdt_nxt     = wdt_r + WDT_W'(1);
         wdt_rst_nxt = &wdt_r;                                  // Wrap raises a one-cycle reset request
      end
   end

   // Watchdog counter register
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         wdt_r <= '0;
      end else begin
         wdt_r <= wdt_nxt;
      end
   end

   // Read mux; prescaler count has no address
   always_comb begin
      rdata_nxt = 8'h00;
      if (i_rd) begin
         if (hit(i_addr, ADDR_TIMER_COUNT)) begin
            rdata_nxt = timer_r;
         end else if (hit(i_addr, ADDR_OPTION)) begin
            rdata_nxt = option_r;
         end else if (hit(i_addr, ADDR_INTR_CTRL) || hit(i_addr, ADDR_INTR_CTRL_HI)) begin
            rdata_nxt = intc_r;
         end else if (hit(i_addr, ADDR_PIN_DIR)) begin
            rdata_nxt = pindir_r;
         end
      end
      irq_nxt = intc_nxt[INTC_OVF_FLAG_BIT] && intc_nxt[INTC_OVF_IE_BIT];
   end

   // Registered outputs; pin direction follows the register in the cycle it is written
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata     <= 8'h00;
         o_wdt_reset <= 1'b0;
         o_timer_irq <= 1'b0;
         o_pin_dir   <= RST_PIN_DIR;
      end else begin
         o_rdata     <= rdata_nxt;
         o_wdt_reset <= wdt_rst_nxt;
         o_timer_irq <= irq_nxt;
         o_pin_dir   <= pindir_nxt;
      end
   end
endmodule // stp_timer_core

// >>> hw/stp_pkg.sv
// Package with register map, field layout and reset values of the shared prescaler
package stp_pkg;
   localparam int          REG_AW              = 9;
   localparam logic [8:0]  ADDR_TIMER_COUNT    = 9'h001;
   localparam logic [8:0]  ADDR_INTR_CTRL      = 9'h00b;
   localparam logic [8:0]  ADDR_INTR_CTRL_HI   = 9'h08b;
   localparam logic [8:0]  ADDR_OPTION         = 9'h081;
   localparam logic [8:0]  ADDR_PIN_DIR        = 9'h085;
   localparam logic [7:0]  RST_OPTION          = 8'hff;
   localparam logic [7:0]  RST_INTR_CTRL       = 8'h00;
   localparam logic [7:0]  RST_PIN_DIR         = 8'h3f;
   localparam logic [7:0]  RST_TIMER_COUNT     = 8'h00;
   localparam logic [7:0]  MASK_PIN_DIR        = 8'h3f;
   localparam int          OPT_ASSIGN_BIT      = 3;
   localparam int          OPT_RATIO_MSB       = 2;
   localparam int          OPT_SRC_BIT         = 5;
   localparam int          OPT_EDGE_BIT        = 4;
   localparam int          INTC_OVF_IE_BIT     = 5;
   localparam int          INTC_OVF_FLAG_BIT   = 2;
   localparam int          PSC_W               = 8;
   localparam int          WDT_W               = 8;
endpackage

// >>> hw/stp_prescale_if.sv
// Interface carrying prescaler controls and the divided tick between core and counter
`timescale 1ns/1ps
interface stp_prescale_if;
   logic       tick_in;     // Event to be divided
   logic       clear;       // Count back to zero
   logic [2:0] ratio;       // Ratio field
   logic       to_wdt;      // Assignment: 1 = watchdog
   logic       tick_out;    // Divided event
   modport core (output tick_in, output clear, output ratio, output to_wdt, input tick_out);
   modport psc  (input tick_in, input clear, input ratio, input to_wdt, output tick_out);
endinterface

// >>> hw/stp_prescaler.sv
// Shared 8-bit prescaler counter with power-of-two tap selection
`timescale 1ns/1ps
module stp_prescaler
   import stp_pkg::*;
(
   input  wire logic    i_clk_sys,
   input  wire logic    i_nrst,
   stp_prescale_if.psc  p_if
);
   logic [PSC_W-1:0] cnt_r;
   logic [PSC_W-1:0] cnt_nxt;
   logic [PSC_W:0]   tap;
   logic             out_nxt;

   // Counter advances on each input event; taps pick the division ratio
   always_comb begin
      cnt_nxt = cnt_r;
      out_nxt = 1'b0;
      // Bit k of tap marks the step that carries into bit k: once per 2**k events
      tap     = {1'b0, cnt_r} ^ ({1'b0, cnt_r} + 9'h001);
      if (p_if.clear) begin
         cnt_nxt = '0;
      end else if (p_if.tick_in) begin
         cnt_nxt = cnt_r + 8'h01;
         // Watchdog divides by 1..128, timer by 2..256
         if (p_if.to_wdt) begin
            out_nxt = tap[p_if.ratio];
         end else begin
            out_nxt = tap[{1'b0, p_if.ratio} + 4'h1];
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_r         <= '0;
         p_if.tick_out <= 1'b0;
      end else begin
         cnt_r         <= cnt_nxt;
         p_if.tick_out <= out_nxt;
      end
   end
endmodule // stp_prescaler

// >>> testbench/stp_core_sva.sv
// Port-level assertions for the shared timer, watchdog and prescaler block
`timescale 1ns/1ps
module stp_core_sva (
   input wire logic                         i_clk_sys,
   input wire logic                         i_nrst,
   input wire logic [stp_pkg::REG_AW-1:0]   i_addr,
   input wire logic                         i_wr,
   input wire logic                         i_rd,
   input wire logic [7:0]                   i_wdata,
   input wire logic                         i_wdt_clear,
   input wire logic                         i_wdt_enable,
   input wire logic [7:0]                   o_rdata,
   input wire logic                         o_wdt_reset,
   input wire logic [7:0]                   o_pin_dir
);
   import stp_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // Read path and register relations
   rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not idle");
   unmapped_read_a: assert property (i_rd && i_addr == 9'h1ff |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   option_readback_a: assert property (i_wr && i_addr == ADDR_OPTION ##1 !i_wr ##1
      i_rd && !i_wr && i_addr == ADDR_OPTION |=> o_rdata == $past(i_wdata, 3)) else $error("option readback");
   timer_write_a: assert property (i_wr && i_addr == ADDR_TIMER_COUNT ##1 !i_wr ##1
      i_rd && !i_wr && i_addr == ADDR_TIMER_COUNT |=> 8'(o_rdata - $past(i_wdata, 3)) <= 8'h02)
      else $error("timer write lost");
   pin_dir_mask_a: assert property (o_pin_dir[7:6] == 2'b00)
      else $error("pin direction upper bits set");
   // Watchdog overflow pulse relations
   wdt_single_a: assert property (o_wdt_reset |=> !o_wdt_reset)
      else $error("watchdog pulse too long");
   wdt_clear_a: assert property (i_wdt_clear |-> ##3 !o_wdt_reset)
      else $error("watchdog fired after clear");
   wdt_disabled_a: assert property (!i_wdt_enable [*3] |-> !o_wdt_reset)
      else $error("watchdog fired while disabled");
endmodule // stp_core_sva

// >>> testbench/testbench.sv
// Self-checking bench for the shared timer, watchdog and prescaler block
`timescale 1ns/1ps
module testbench;
   import stp_pkg::*;
   logic              i_clk_sys = 1'b0;
   logic              i_nrst = 1'b0;
   logic [REG_AW-1:0] i_addr = '0;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic [7:0]        i_wdata = 8'h00;
   logic              i_wdt_clear = 1'b0;
   logic              i_wdt_enable = 1'b1;
   logic              i_wdt_osc_tick = 1'b1;
   logic              i_ext_clk = 1'b0;
   logic [7:0]        o_rdata, o_pin_dir, v;
   logic              o_wdt_reset, o_timer_irq;
   int                miscompares = 0, compares = 0, n, s;
   logic [8:0]        ra [4] = '{ADDR_OPTION, ADDR_INTR_CTRL, ADDR_PIN_DIR, ADDR_TIMER_COUNT};
   logic [7:0]        rv [4] = '{8'hff, 8'h00, 8'h3f, 8'h00};
   stp_timer_core u_dut (.i_clk_sys, .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata, .i_wdt_clear, .i_wdt_enable,
      .i_wdt_osc_tick, .i_ext_clk, .o_rdata, .o_wdt_reset, .o_timer_irq, .o_pin_dir);
   // Clock source
   initial begin
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   // Comparison, verdict, bus access and watchdog clear helpers
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic clr;
      @(posedge i_clk_sys);
      i_wdt_clear <= 1'b1;
      @(posedge i_clk_sys);
      i_wdt_clear <= 1'b0;
   endtask
   // Cycles until the next watchdog pulse, bounded
   task automatic wpulse;
      for (n = 0; n < 40000; n++) begin
         @(posedge i_clk_sys);
         #1;
         if (o_wdt_reset === 1'b1) break;
      end
      if (n == 40000) begin
         miscompares++;
         print_verdict();
      end
   endtask
   // Timer advance over four division periods
   task automatic meas(input int p, input string nm);
      logic [7:0] a;
      rd(ADDR_TIMER_COUNT, a);
      repeat (4 * p - 2) @(posedge i_clk_sys);
      rd(ADDR_TIMER_COUNT, v);
      chk(nm, 8'h04, 8'(v - a));
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(ra[k], v);
         chk("reset_value", rv[k], v);
      end
      rd(9'h1ff, v);
      chk("unmapped", 8'h00, v);
      wr(ADDR_PIN_DIR, 8'hea);
      rd(ADDR_PIN_DIR, v);
      chk("pin_dir_read", 8'h2a, v);
      chk("pin_dir", 8'h2a, o_pin_dir);
      @(posedge i_clk_sys) i_wdt_enable <= 1'b0;
      clr();
      for (int r = 0; r < 8; r++) begin
         wr(ADDR_OPTION, 8'(r));
         rd(ADDR_OPTION, v);
         chk("option", 8'(r), v);
         meas(2 << r, "timer_ratio");
      end
      repeat (3) begin
         wr(ADDR_TIMER_COUNT, 8'h10);
         rd(ADDR_TIMER_COUNT, v);
         chk("timer_write", 8'h10, v);
         repeat (246) @(posedge i_clk_sys);
         rd(ADDR_TIMER_COUNT, v);
         chk("timer_clear", 8'h10, v);
      end
      @(posedge i_clk_sys) i_wdt_enable <= 1'b1;
      clr();
      wr(ADDR_TIMER_COUNT, 8'h00);
      wr(ADDR_OPTION, 8'h2f);
      clr();
      for (int r = 0; r < 3; r++) begin
         wr(ADDR_OPTION, 8'h08 | 8'(r));
         clr();
         wpulse();
         wpulse();
         chk("wdt_ratio", (256 << r) - 1, n);
      end
      meas(1, "timer_undivided");
      s = 0;
      repeat (5) begin
         repeat (300) begin
            @(posedge i_clk_sys);
            #1 if (o_wdt_reset !== 1'b0) s++;
         end
         clr();
      end
      chk("wdt_clear", 0, s);
      wr(ADDR_OPTION, 8'h00);
      meas(2, "timer_back");
      // Overflow flag and interrupt output, set by a wrap and cleared by software
      wr(ADDR_TIMER_COUNT, 8'h00);
      wr(ADDR_INTR_CTRL, 8'h20);
      rd(ADDR_INTR_CTRL, v);
      chk("intr_ctrl", 8'h20, v);
      chk("timer_irq", 1'b0, o_timer_irq);
      wr(ADDR_TIMER_COUNT, 8'hfe);
      repeat (10) @(posedge i_clk_sys);
      rd(ADDR_INTR_CTRL_HI, v);
      chk("overflow_flag", 8'h24, v);
      chk("timer_irq", 1'b1, o_timer_irq);
      wr(ADDR_INTR_CTRL, 8'h00);
      rd(ADDR_INTR_CTRL, v);
      chk("overflow_clear", 8'h00, v);
      chk("timer_irq", 1'b0, o_timer_irq);
      print_verdict();
   end
endmodule // testbench
bind stp_timer_core stp_core_sva u_sva (.i_clk_sys, .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata, .i_wdt_clear,
   .i_wdt_enable, .o_rdata, .o_wdt_reset, .o_pin_dir);
